// File: core/dc_pkg.sv
// Shared constants, types and helpers of the data cache
package dc_pkg;
	// ****************************************
	// Geometry
	// ****************************************
	localparam int VA_W     = 48;
	localparam int TAG_W    = 28;
	localparam int DW       = 64;
	localparam int D_AW     = 11;
	localparam int TAG_AW   = 9;
	localparam int VAL_AW   = 10;
	localparam int VAL_W    = 4;
	localparam int TLB_AW   = 7;
	localparam int WAYS     = 3;
	localparam int VT_W     = 29;
	localparam int VTE_W    = 30;
	localparam int PA_LW    = WAYS * TAG_W;
	localparam int VT_LW    = WAYS * VTE_W;
	// ****************************************
	// Address fields
	// ****************************************
	localparam int D_LSB    = 3;
	localparam int LINE_LSB = 5;
	localparam int VAL_LSB  = 4;
	localparam int PG_LSB   = 12;
	localparam int VT_LSB   = 19;
	localparam int CNT_W    = 4;
	localparam logic [1:0]       LAST_BEAT = 2'h3;
	localparam logic [1:0]       FIN_DONE  = 2'h2;
	localparam logic [1:0]       SZ_DW     = 2'h3;
	localparam logic [CNT_W-1:0] MISS_CYC  = 4'h8;
	localparam logic [VAL_W-1:0] VAL_ALL   = 4'hF;
	localparam logic [VAL_W-1:0] VAL_LO    = 4'h3;
	localparam logic [VAL_W-1:0] VAL_HI    = 4'hC;

	typedef enum logic [3:0] {
		ST_INIT = 4'h1,
		ST_IDLE = 4'h2,
		ST_FILL = 4'h4,
		ST_FIN  = 4'h8
	} fsm_t;

	// Byte enables of an access size, unshifted
	function automatic logic [7:0] size_mask(input logic [1:0] sz);
		case (sz)
			2'h0: return 8'h01;
			2'h1: return 8'h03;
			2'h2: return 8'h0F;
			default: return 8'hFF;
		endcase
	endfunction : size_mask

	function automatic logic [DW-1:0] byte_bits(input logic [7:0] be);
		logic [DW-1:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i*8 +: 8] = {8{be[i]}};
		end
		return r;
	endfunction : byte_bits
endpackage : dc_pkg

// File: core/dcache_core.sv
// Dual ported write-through data cache with translation buffer
//
// Notes on behaviour
// - 2048 x 64-bit data, two ports
// - Line is 32 bytes, four doublewords
// - Two loads or load plus store only
// - Virtual index, physical tag, write-through
// - Two load aligners right-justify narrow reads
// - One store aligner places bytes in lanes
// - Byte writes chosen by address bits 2:0
// - Second-level store carries at least 32 bits
// - Tag array 512 entries of 28 bits
// - Data, tag and translation read together
// - Load hit writes register file at once
// - Load miss: no write, start refill
// - Missing store clears valid next clock
// - Translation: two halves, 128 sets, 3-way
// - Virtual tag match selects physical page
// - Cache miss with a translation hit starts an external cycle; translation miss does not
// - Valid array 1024 x 4, one per word
// - Floating point store clears word valid
// - Load of invalid word is a miss
// - Valid bits checked on loads and stores
// - Missing store also allocates the line
// - Refill occupies eight cycles at least
`timescale 1ns/100ps
module dcache_core (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [1:0]       p_req,
	input  wire logic [1:0]       p_store,
	input  wire logic [1:0][47:0] p_va,
	input  wire logic [1:0][1:0]  p_size,
	input  wire logic [1:0][63:0] p_wdata,
	output logic [1:0]            p_rf_we,
	output logic [1:0][63:0]      p_rf_data,
	output logic [1:0]            p_hit,
	output logic [1:0]            p_miss,
	output logic [1:0]            p_tlb_miss,
	output logic                  busy,
	output logic                  l2_wr,
	output logic [39:0]           l2_wr_addr,
	output logic [63:0]           l2_wr_data,
	output logic [7:0]            l2_wr_be,
	output logic                  l2_fill_req,
	output logic [39:0]           l2_fill_addr,
	input  wire logic             l2_fill_valid,
	input  wire logic [63:0]      l2_fill_data,
	input  wire logic             fp_inv,
	input  wire logic [11:0]      fp_inv_word,
	output logic                  fp_inv_busy,
	input  wire logic             tlb_wr,
	input  wire logic [1:0]       tlb_wr_way,
	input  wire logic [47:0]      tlb_wr_va,
	input  wire logic [27:0]      tlb_wr_ppn,
	input  wire logic             tlb_wr_vld
);
	typedef struct packed {
		dc_pkg::fsm_t      st;
		logic [1:0]        s1_v;
		logic [1:0]        s1_st;
		logic [1:0][47:0]  s1_va;
		logic [1:0][1:0]   s1_sz;
		logic [1:0][63:0]  s1_wd;
		logic [1:0][7:0]   s1_be;
		logic [1:0]        rf_we;
		logic [1:0][63:0]  rf_data;
		logic [1:0]        hit;
		logic [1:0]        miss;
		logic [1:0]        tlb_miss;
		logic              busy;
		logic              l2_wr;
		logic [39:0]       l2_wr_addr;
		logic [63:0]       l2_wr_data;
		logic [7:0]        l2_wr_be;
		logic              fill_req;
		logic [39:0]       fill_addr;
		logic [8:0]        fill_line;
		logic [1:0]        beat;
		logic [3:0]        cnt;
		logic [9:0]        sw;
		logic              clr_v;
		logic [9:0]        clr_idx;
		logic [3:0]        clr_mask;
		logic              inv_pend;
		logic [11:0]       inv_word;
	} core_t;

	localparam core_t RST_VAL = '{st: dc_pkg::ST_INIT, busy: 1'b1, default: '0};

	core_t                c;
	core_t                n;
	logic [1:0]           acc;
	logic [1:0]           stw;
	logic [1:0]           thit;
	logic [1:0]           hitw;
	logic [1:0][27:0]     ppn;
	logic [1:0][3:0]      vneed;
	logic [1:0][63:0]     ld_al;
	logic [29:0]          e;
	logic [63:0]          bm;
	logic                 fillw;
	logic                 sp;

	ram_if #(.AW(dc_pkg::D_AW), .DW(dc_pkg::DW))        dat_if ();
	ram_if #(.AW(dc_pkg::TAG_AW), .DW(dc_pkg::TAG_W))   tag_if ();
	ram_if #(.AW(dc_pkg::VAL_AW), .DW(dc_pkg::VAL_W))   val_if ();
	ram_if #(.AW(dc_pkg::TLB_AW), .DW(dc_pkg::VT_LW))   vt_if ();
	ram_if #(.AW(dc_pkg::TLB_AW), .DW(dc_pkg::PA_LW))   pa_if ();

	// ****************************************
	// Arrays
	// ****************************************
	// Data array, 16 KB dual ported
	dp_ram #(.AW(dc_pkg::D_AW), .DW(dc_pkg::DW)) u_data (.sys_clk(sys_clk), .bus(dat_if));
	// Physical tag per line
	dp_ram #(.AW(dc_pkg::TAG_AW), .DW(dc_pkg::TAG_W)) u_tag (.sys_clk(sys_clk), .bus(tag_if));
	// One valid bit per word
	dp_ram #(.AW(dc_pkg::VAL_AW), .DW(dc_pkg::VAL_W)) u_val (.sys_clk(sys_clk), .bus(val_if));
	// Translation halves, 3 ways per set
	dp_ram #(.AW(dc_pkg::TLB_AW), .DW(dc_pkg::VT_LW)) u_virtual_tag_half (.sys_clk(sys_clk), .bus(vt_if));
	dp_ram #(.AW(dc_pkg::TLB_AW), .DW(dc_pkg::PA_LW)) u_physical_address_half (.sys_clk(sys_clk), .bus(pa_if));

	// Load aligners, one per port
	for (genvar gp = 0; gp < 2; gp++) begin : g_al
		load_align u_al (
			.dword(dat_if.rd_data[gp]),
			.off  (c.s1_va[gp][2:0]),
			.size (c.s1_sz[gp]),
			.data (ld_al[gp])
		);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n = c;
		n.rf_we = '0;
		n.hit = '0;
		n.miss = '0;
		n.tlb_miss = '0;
		n.l2_wr = 1'b0;
		n.fill_req = 1'b0;
		n.clr_v = 1'b0;
		thit = '0;
		hitw = '0;
		ppn = '0;
		vneed = '0;
		e = '0;
		bm = '0;
		// Request capture and array addressing, same cycle for all arrays
		for (int p = 0; p < 2; p++) begin
			acc[p] = p_req[p] & ~c.busy;
			stw[p] = acc[p] & p_store[p];
			dat_if.rd_addr[p] = p_va[p][dc_pkg::D_LSB +: dc_pkg::D_AW];
			tag_if.rd_addr[p] = p_va[p][dc_pkg::LINE_LSB +: dc_pkg::TAG_AW];
			val_if.rd_addr[p] = p_va[p][dc_pkg::VAL_LSB +: dc_pkg::VAL_AW];
			vt_if.rd_addr[p] = p_va[p][dc_pkg::PG_LSB +: dc_pkg::TLB_AW];
			pa_if.rd_addr[p] = p_va[p][dc_pkg::PG_LSB +: dc_pkg::TLB_AW];
			n.s1_wd[p] = p_wdata[p] << {p_va[p][2:0], 3'h0};
			n.s1_be[p] = dc_pkg::size_mask(p_size[p]) << p_va[p][2:0];
		end
		acc[1] = acc[1] & ~(stw[0] & stw[1]); // Refused store gets no answer
		stw[1] = stw[1] & ~stw[0]; // Second store in a cycle dropped
		n.s1_v = acc;
		n.s1_st = stw;
		n.s1_va = p_va;
		n.s1_sz = p_size;

		// Store writes the array before the lookup resolves
		fillw = (c.st == dc_pkg::ST_FILL) && l2_fill_valid;
		sp = stw[1];
		dat_if.wr_en = fillw | (|stw);
		if (fillw) begin
			dat_if.wr_addr = {c.fill_line, c.beat};
			dat_if.wr_data = l2_fill_data;
			dat_if.wr_mask = '1;
		end else begin
			dat_if.wr_addr = p_va[sp][dc_pkg::D_LSB +: dc_pkg::D_AW];
			dat_if.wr_data = n.s1_wd[sp];
			dat_if.wr_mask = dc_pkg::byte_bits(n.s1_be[sp]);
		end
		tag_if.wr_en = (c.st == dc_pkg::ST_FIN) && (c.beat == 2'h0);
		tag_if.wr_addr = c.fill_line;
		tag_if.wr_data = c.fill_addr[39:12];
		tag_if.wr_mask = '1;

		// Translation buffer writes, virtual tag half cleared during the start sweep
		vt_if.wr_en = tlb_wr | (c.st == dc_pkg::ST_INIT);
		pa_if.wr_en = tlb_wr;
		vt_if.wr_addr = tlb_wr_va[dc_pkg::PG_LSB +: dc_pkg::TLB_AW];
		pa_if.wr_addr = tlb_wr_va[dc_pkg::PG_LSB +: dc_pkg::TLB_AW];
		vt_if.wr_data = {dc_pkg::WAYS{tlb_wr_vld, tlb_wr_va[dc_pkg::VT_LSB +: dc_pkg::VT_W]}};
		pa_if.wr_data = {dc_pkg::WAYS{tlb_wr_ppn}};
		for (int w = 0; w < dc_pkg::WAYS; w++) begin
			vt_if.wr_mask[w*dc_pkg::VTE_W +: dc_pkg::VTE_W] = {dc_pkg::VTE_W{tlb_wr_way == 2'(w)}};
			pa_if.wr_mask[w*dc_pkg::TAG_W +: dc_pkg::TAG_W] = {dc_pkg::TAG_W{tlb_wr_way == 2'(w)}};
		end
		if (c.st == dc_pkg::ST_INIT) begin
			vt_if.wr_addr = c.sw[6:0];
			vt_if.wr_data = '0;
			vt_if.wr_mask = '1;
		end

		// ****************************************
		// Refill sequencer
		// ****************************************
		if (c.cnt < dc_pkg::MISS_CYC) begin
			n.cnt = c.cnt + 4'h1;
		end
		case (c.st)
			dc_pkg::ST_INIT: begin
				n.sw = c.sw + 10'h1;
				if (&c.sw) begin
					n.st = dc_pkg::ST_IDLE;
					n.busy = 1'b0;
				end
			end
			dc_pkg::ST_IDLE: begin
				n.busy = 1'b0;
			end
			dc_pkg::ST_FILL: begin
				if (fillw) begin
					n.beat = c.beat + 2'h1;
					if (c.beat == dc_pkg::LAST_BEAT) begin
						n.st = dc_pkg::ST_FIN;
					end
				end
			end
			dc_pkg::ST_FIN: begin
				if (!c.clr_v && c.beat != dc_pkg::FIN_DONE) begin
					n.beat = c.beat + 2'h1;
				end
				// Busy held for the full miss penalty
				if (c.beat == dc_pkg::FIN_DONE && c.cnt >= dc_pkg::MISS_CYC - 4'h1) begin
					n.st = dc_pkg::ST_IDLE;
					n.busy = 1'b0;
				end
			end
			default: begin
				n.st = dc_pkg::ST_IDLE;
			end
		endcase

		// ****************************************
		// Lookup and result
		// ****************************************
		for (int p = 0; p < 2; p++) begin
			for (int w = 0; w < dc_pkg::WAYS; w++) begin
				e = vt_if.rd_data[p][w*dc_pkg::VTE_W +: dc_pkg::VTE_W];
				if (e[dc_pkg::VT_W] && e[dc_pkg::VT_W-1:0] == c.s1_va[p][dc_pkg::VT_LSB +: dc_pkg::VT_W]) begin
					thit[p] = 1'b1;
					ppn[p] = pa_if.rd_data[p][w*dc_pkg::TAG_W +: dc_pkg::TAG_W];
				end
			end
			if (c.s1_sz[p] == dc_pkg::SZ_DW) begin
				vneed[p] = c.s1_va[p][3] ? dc_pkg::VAL_HI : dc_pkg::VAL_LO;
			end else begin
				vneed[p] = 4'h1 << c.s1_va[p][3:2];
			end
			// Tag compare plus word valid, loads and stores alike
			hitw[p] = thit[p] && tag_if.rd_data[p] == ppn[p]
				&& (val_if.rd_data[p] & vneed[p]) == vneed[p];
			if (c.s1_v[p]) begin
				n.hit[p] = hitw[p];
				n.tlb_miss[p] = ~thit[p];
				if (!c.s1_st[p]) begin
					n.rf_we[p] = hitw[p];
					n.rf_data[p] = ld_al[p];
					n.miss[p] = ~hitw[p];
				end else begin
					if (thit[p]) begin
						bm = dc_pkg::byte_bits(c.s1_be[p]);
						n.l2_wr = 1'b1;
						n.l2_wr_addr = {ppn[p], c.s1_va[p][11:3], 3'h0};
						n.l2_wr_data = (dat_if.rd_data[p] & ~bm) | (c.s1_wd[p] & bm);
						n.l2_wr_be = {{4{|c.s1_be[p][7:4]}}, {4{|c.s1_be[p][3:0]}}};
					end
					if (!hitw[p]) begin
						n.miss[p] = 1'b1;
						n.clr_v = 1'b1;
						n.clr_idx = c.s1_va[p][dc_pkg::VAL_LSB +: dc_pkg::VAL_AW];
						n.clr_mask = vneed[p];
					end
				end
				// Miss of load or store with a translation hit launches a line refill
				if (!hitw[p] && thit[p] && c.st == dc_pkg::ST_IDLE && n.st == dc_pkg::ST_IDLE) begin
					n.st = dc_pkg::ST_FILL;
					n.busy = 1'b1;
					n.fill_req = 1'b1;
					n.fill_addr = {ppn[p], c.s1_va[p][11:5], 5'h0};
					n.fill_line = c.s1_va[p][dc_pkg::LINE_LSB +: dc_pkg::TAG_AW];
					n.beat = 2'h0;
					n.cnt = 4'h0;
				end
			end
		end

		// ****************************************
		// Valid array write arbitration
		// ****************************************
		val_if.wr_en = 1'b1;
		val_if.wr_data = '0;
		val_if.wr_mask = dc_pkg::VAL_ALL;
		val_if.wr_addr = c.sw;
		if (c.st == dc_pkg::ST_INIT) begin
			val_if.wr_addr = c.sw;
		end else if (c.clr_v) begin
			val_if.wr_addr = c.clr_idx;
			val_if.wr_mask = c.clr_mask;
		end else if (c.st == dc_pkg::ST_FIN && c.beat != dc_pkg::FIN_DONE) begin
			val_if.wr_addr = {c.fill_line, c.beat[0]};
			val_if.wr_data = dc_pkg::VAL_ALL;
		end else if (c.inv_pend) begin
			val_if.wr_addr = c.inv_word[11:2];
			val_if.wr_mask = 4'h1 << c.inv_word[1:0];
			n.inv_pend = 1'b0;
		end else begin
			val_if.wr_en = 1'b0;
		end
		if (fp_inv && !c.inv_pend) begin
			n.inv_pend = 1'b1;
			n.inv_word = fp_inv_word;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			c <= RST_VAL;
		end else begin
			c <= n;
		end
	end

	assign p_rf_we = c.rf_we;
	assign p_rf_data = c.rf_data;
	assign p_hit = c.hit;
	assign p_miss = c.miss;
	assign p_tlb_miss = c.tlb_miss;
	assign busy = c.busy;
	assign l2_wr = c.l2_wr;
	assign l2_wr_addr = c.l2_wr_addr;
	assign l2_wr_data = c.l2_wr_data;
	assign l2_wr_be = c.l2_wr_be;
	assign l2_fill_req = c.fill_req;
	assign l2_fill_addr = c.fill_addr;
	assign fp_inv_busy = c.inv_pend;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_one_store;
		!(c.s1_st[0] && c.s1_st[1]);
	endproperty
	a_one_store: assert property (p_one_store) else $error("two stores in one cycle");

	property p_load_hit;
		c.s1_v[0] && !c.s1_st[0] && hitw[0] |=> p_rf_we[0] && !p_miss[0];
	endproperty
	a_load_hit: assert property (p_load_hit) else $error("load hit not written");

	property p_load_miss;
		c.s1_v[1] && !c.s1_st[1] && !hitw[1] |=> !p_rf_we[1] && p_miss[1];
	endproperty
	a_load_miss: assert property (p_load_miss) else $error("load miss wrote register file");

	property p_store_fwd;
		c.s1_v[0] && c.s1_st[0] && thit[0] |=> l2_wr && l2_wr_addr[39:12] == $past(ppn[0]);
	endproperty
	a_store_fwd: assert property (p_store_fwd) else $error("store not forwarded");

	property p_wide_fwd;
		l2_wr |-> (l2_wr_be[3:0] == 4'hF || l2_wr_be[7:4] == 4'hF) && l2_wr_be != 8'hFF ##0 1'b1
			or l2_wr_be == 8'hFF;
	endproperty
	a_wide_fwd: assert property (p_wide_fwd) else $error("forwarded store under 32 bits");

	property p_clr_next;
		c.s1_v[0] && c.s1_st[0] && !hitw[0] |=> val_if.wr_en && val_if.wr_data == '0
			&& val_if.wr_addr == $past(c.s1_va[0][dc_pkg::VAL_LSB +: dc_pkg::VAL_AW]);
	endproperty
	a_clr_next: assert property (p_clr_next) else $error("store miss valid not cleared");

	property p_penalty;
		$rose(busy) && !$past(c.st == dc_pkg::ST_INIT) |-> busy [*8];
	endproperty
	a_penalty: assert property (p_penalty) else $error("refill shorter than penalty");

	property p_refill_req;
		l2_fill_req |-> busy && c.st == dc_pkg::ST_FILL;
	endproperty
	a_refill_req: assert property (p_refill_req) else $error("refill request without fill");

	property p_fin_tag;
		c.st == dc_pkg::ST_FIN && c.beat == 2'h0 |-> tag_if.wr_en && val_if.wr_en;
	endproperty
	a_fin_tag: assert property (p_fin_tag) else $error("refill tag not written");

	property p_inv_served;
		fp_inv_busy |-> ##[0:12] !fp_inv_busy;
	endproperty
	a_inv_served: assert property (p_inv_served) else $error("float invalidate stuck");

	property p_invalid_load;
		c.s1_v[0] && !c.s1_st[0] && (val_if.rd_data[0] & vneed[0]) != vneed[0] |=> !p_rf_we[0];
	endproperty
	a_invalid_load: assert property (p_invalid_load) else $error("invalid word returned");
endmodule : dcache_core

// File: core/dp_ram.sv
// Dual read, single bit-masked write RAM with registered read data
`timescale 1ns/100ps
module dp_ram #(parameter int AW = 1, parameter int DW = 1) (
	input wire logic sys_clk,
	ram_if.mem       bus
);
	logic [DW-1:0]      mem [0:(1<<AW)-1];
	logic [1:0][DW-1:0] rdq;

	always_ff @(posedge sys_clk) begin
		if (bus.wr_en) begin
			mem[bus.wr_addr] <= (mem[bus.wr_addr] & ~bus.wr_mask) | (bus.wr_data & bus.wr_mask);
		end
		for (int i = 0; i < 2; i++) begin
			rdq[i] <= mem[bus.rd_addr[i]];
		end
	end

	assign bus.rd_data = rdq;
endmodule : dp_ram

// File: core/load_align.sv
// Shifts a narrow load down to the low end of the register
`timescale 1ns/100ps
module load_align (
	input  wire logic [63:0] dword,
	input  wire logic [2:0]  off,
	input  wire logic [1:0]  size,
	output logic [63:0]      data
);
	always_comb begin
		data = (dword >> {off, 3'h0}) & dc_pkg::byte_bits(dc_pkg::size_mask(size));
	end
endmodule : load_align

// File: core/ram_if.sv
// Two read ports and one masked write port of a RAM
`timescale 1ns/100ps
interface ram_if #(parameter int AW = 1, parameter int DW = 1);
	logic [1:0][AW-1:0] rd_addr;
	logic [1:0][DW-1:0] rd_data;
	logic               wr_en;
	logic [AW-1:0]      wr_addr;
	logic [DW-1:0]      wr_data;
	logic [DW-1:0]      wr_mask;
	modport ctrl (output rd_addr, wr_en, wr_addr, wr_data, wr_mask, input rd_data);
	modport mem (input rd_addr, wr_en, wr_addr, wr_data, wr_mask, output rd_data);
endinterface : ram_if

// File: tb/dual_port_data_cache_tlb_tb.sv
// Self-checking bench of the data cache
`timescale 1ns/100ps
module dual_port_data_cache_tlb_tb;
	localparam logic [47:0] VB  = 48'h000012345040;
	localparam logic [27:0] PPN = 28'h00ABCDE;
	localparam logic [39:0] LN0 = {PPN, 12'h040};
	logic             sys_clk = 1'b0;
	logic             rst     = 1'b1;
	logic             slow    = 1'b0;
	logic [1:0]       p_req   = 2'h0;
	logic [1:0]       p_store = 2'h0;
	logic [1:0][47:0] p_va    = '0;
	logic [1:0][1:0]  p_size  = '0;
	logic [1:0][63:0] p_wdata = '0;
	logic [1:0]       p_rf_we, p_hit, p_miss, p_tlb_miss;
	logic [1:0][63:0] p_rf_data;
	logic             busy, l2_wr, l2_fill_req, l2_fill_valid, fp_inv_busy;
	logic [39:0]      l2_wr_addr, l2_fill_addr;
	logic [63:0]      l2_wr_data, l2_fill_data;
	logic [7:0]       l2_wr_be;
	logic             fp_inv      = 1'b0;
	logic [11:0]      fp_inv_word = 12'h0;
	logic             tlb_wr      = 1'b0;
	logic [1:0]       tlb_wr_way  = 2'h0;
	logic [47:0]      tlb_wr_va   = 48'h0;
	logic [27:0]      tlb_wr_ppn  = 28'h0;
	logic             tlb_wr_vld  = 1'b0;
	int               fails, check_count, lat, n;
	logic [63:0]      d;
	typedef struct {logic [1:0] rq; logic [4:0] o0; logic [1:0] s0; logic [4:0] o1; logic [1:0] s1;} row_t;
	row_t rows [5] = '{'{2'h3, 5'h00, 2'h3, 5'h18, 2'h3}, '{2'h3, 5'h0C, 2'h2, 5'h12, 2'h1},
		'{2'h3, 5'h07, 2'h0, 5'h1E, 2'h1}, '{2'h1, 5'h09, 2'h0, 5'h00, 2'h0}, '{2'h2, 5'h00, 2'h0, 5'h15, 2'h0}};

	always #12.5 sys_clk = ~sys_clk;

	dcache_core u_dut (.sys_clk(sys_clk), .rst(rst), .p_req(p_req), .p_store(p_store), .p_va(p_va),
		.p_size(p_size), .p_wdata(p_wdata), .p_rf_we(p_rf_we), .p_rf_data(p_rf_data), .p_hit(p_hit),
		.p_miss(p_miss), .p_tlb_miss(p_tlb_miss), .busy(busy), .l2_wr(l2_wr), .l2_wr_addr(l2_wr_addr),
		.l2_wr_data(l2_wr_data), .l2_wr_be(l2_wr_be), .l2_fill_req(l2_fill_req), .l2_fill_addr(l2_fill_addr),
		.l2_fill_valid(l2_fill_valid), .l2_fill_data(l2_fill_data), .fp_inv(fp_inv), .fp_inv_word(fp_inv_word),
		.fp_inv_busy(fp_inv_busy), .tlb_wr(tlb_wr), .tlb_wr_way(tlb_wr_way), .tlb_wr_va(tlb_wr_va),
		.tlb_wr_ppn(tlb_wr_ppn), .tlb_wr_vld(tlb_wr_vld));

	l2_model u_l2 (.sys_clk(sys_clk), .rst(rst), .slow(slow), .l2_fill_req(l2_fill_req),
		.l2_fill_addr(l2_fill_addr), .l2_fill_valid(l2_fill_valid), .l2_fill_data(l2_fill_data));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [63:0] ld_exp(input logic [39:0] ln, input logic [4:0] off, input logic [1:0] sz);
		logic [63:0] a;
		a = {24'h0, ln[39:0] + {35'h0, off[4:3], 3'h0}};
		a = {~a[31:0], a[31:0]} >> (off[2:0] * 8);
		return (sz == 2'h3) ? a : a & ((64'h1 << (8 << sz)) - 64'h1);
	endfunction : ld_exp

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic go(input logic [1:0] rq, input logic [1:0] st, input logic [1:0][47:0] va,
		input logic [1:0][1:0] sz, input logic [1:0][63:0] wd);
		@(posedge sys_clk);
		p_req   <= rq;
		p_store <= st;
		p_va    <= va;
		p_size  <= sz;
		p_wdata <= wd;
		@(posedge sys_clk);
		p_req <= 2'h0;
		lat = 1;
		do begin
			@(posedge sys_clk);
			#1;
			lat++;
		end while ((p_hit | p_miss | p_tlb_miss) === 2'h0 && lat < 5);
		chk("latency", 64'(lat), 64'h2);
	endtask : go

	task automatic wait_idle(input int lim);
		n = 0;
		while (busy !== 1'b0 && n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("busy", 64'(busy), 64'h0);
	endtask : wait_idle

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (6000) @(posedge sys_clk);
		fails++;
		final_report();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		@(posedge sys_clk);
		#1;
		chk("busy_in_reset", 64'(busy), 64'h1);
		chk("rf_we_in_reset", 64'(p_rf_we), 64'h0);
		@(posedge sys_clk);
		rst <= 1'b0;
		wait_idle(1100);
		@(posedge sys_clk);
		{tlb_wr, tlb_wr_way, tlb_wr_va, tlb_wr_ppn, tlb_wr_vld} <= {1'b1, 2'h1, VB, PPN, 1'b1};
		@(posedge sys_clk);
		tlb_wr <= 1'b0;
		$display("reset and translation done");
		go(2'h1, 2'h0, {48'h0, VB}, 4'hF, '0);
		chk("miss", 64'(p_miss), 64'h1);
		chk("rf_we", 64'(p_rf_we), 64'h0);
		chk("fill_req", 64'(l2_fill_req), 64'h1);
		chk("fill_addr", 64'(l2_fill_addr), 64'(LN0));
		n = 1;
		while (busy === 1'b1 && n < 60) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("refill_len", 64'(n >= 8), 64'h1);
		$display("load miss done");
		foreach (rows[i]) begin
			go(rows[i].rq, 2'h0, {VB + 48'(rows[i].o1), VB + 48'(rows[i].o0)}, {rows[i].s1, rows[i].s0}, '0);
			chk("hit", 64'(p_hit), 64'(rows[i].rq));
			chk("rf_we", 64'(p_rf_we), 64'(rows[i].rq));
			if (rows[i].rq[0]) chk("rf0", p_rf_data[0], ld_exp(LN0, rows[i].o0, rows[i].s0));
			if (rows[i].rq[1]) chk("rf1", p_rf_data[1], ld_exp(LN0, rows[i].o1, rows[i].s1));
		end
		$display("load rows done");
		d = (ld_exp(LN0, 5'h0, 2'h3) & ~64'hFF000000) | 64'h5A000000;
		go(2'h1, 2'h1, {48'h0, VB + 48'h3}, 4'h0, {64'h0, 64'h5A});
		chk("l2_wr", 64'(l2_wr), 64'h1);
		chk("wr_addr", 64'(l2_wr_addr), 64'(LN0));
		chk("wr_be", 64'(l2_wr_be), 64'h0F);
		chk("wr_data", l2_wr_data & 64'hFFFFFFFF, d & 64'hFFFFFFFF);
		go(2'h1, 2'h0, {48'h0, VB}, 4'hF, '0);
		chk("merged", p_rf_data[0], d);
		go(2'h3, 2'h3, {VB + 48'h10, VB + 48'h8}, 4'h0, {64'h77, 64'h66});
		chk("two_stores", 64'(p_hit), 64'h1);
		go(2'h1, 2'h0, {48'h0, VB + 48'h10}, 4'h0, '0);
		chk("dropped", p_rf_data[0], ld_exp(LN0, 5'h10, 2'h0));
		$display("store tests done");
		@(posedge sys_clk);
		fp_inv      <= 1'b1;
		fp_inv_word <= VB[13:2] + 12'h1;
		@(posedge sys_clk);
		fp_inv <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (fp_inv_busy !== 1'b0 && n < 14);
		chk("fp_inv_busy", 64'(fp_inv_busy), 64'h0);
		go(2'h1, 2'h0, {48'h0, VB}, 4'h2, '0);
		chk("other_word", 64'(p_hit), 64'h1);
		slow <= 1'b1;
		go(2'h1, 2'h0, {48'h0, VB + 48'h4}, 4'h2, '0);
		chk("fp_word_miss", 64'(p_miss), 64'h1);
		wait_idle(60);
		go(2'h1, 2'h0, {48'h0, VB + 48'h4}, 4'h2, '0);
		chk("refilled", p_rf_data[0], ld_exp(LN0, 5'h4, 2'h2));
		$display("invalidate done");
		go(2'h1, 2'h1, {48'h0, VB + 48'h40}, 4'h3, {64'h0, 64'h1122334455667788});
		chk("st_miss", 64'(p_miss), 64'h1);
		chk("st_fwd", l2_wr_data, 64'h1122334455667788);
		chk("st_be", 64'(l2_wr_be), 64'hFF);
		chk("st_fill", 64'(l2_fill_addr), 64'(LN0 + 40'h40));
		wait_idle(60);
		go(2'h1, 2'h0, {48'h0, VB + 48'h58}, 4'h3, '0);
		chk("alloc", p_rf_data[0], ld_exp(LN0 + 40'h40, 5'h18, 2'h3));
		go(2'h3, 2'h0, {48'h000099990000, 48'h000099990000}, 4'h0, '0);
		chk("tlb_miss", 64'(p_tlb_miss), 64'h3);
		chk("tlb_ld_miss", 64'(p_miss), 64'h3);
		chk("tlb_rf_we", 64'(p_rf_we), 64'h0);
		$display("miss tests done");
		final_report();
	end
endmodule : dual_port_data_cache_tlb_tb

// File: tb/l2_model.sv
// Second-level cache model answering line refills
`timescale 1ns/100ps
module l2_model (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        slow,
	input  wire logic        l2_fill_req,
	input  wire logic [39:0] l2_fill_addr,
	output logic             l2_fill_valid = 1'b0,
	output logic [63:0]      l2_fill_data  = 64'h0
);
	// ****************************************
	// Refill beats
	// ****************************************
	function automatic logic [63:0] beat_data(input logic [39:0] a);
		return {~a[31:0], a[31:0]};
	endfunction : beat_data

	logic [39:0] line;

	always begin
		@(posedge sys_clk);
		if (!rst && l2_fill_req === 1'b1) begin
			line = l2_fill_addr;
			repeat (slow ? 6 : 1) @(posedge sys_clk);
			// Four dwords in address order
			for (int b = 0; b < 4; b++) begin
				l2_fill_valid <= 1'b1;
				l2_fill_data  <= beat_data(line + 40'(b * 8));
				@(posedge sys_clk);
			end
			l2_fill_valid <= 1'b0;
		end
		// Idle bus keeps changing
		l2_fill_data <= ~l2_fill_data;
	end
endmodule : l2_model
